// ===== design/pcu_pkg.sv
package pcu_pkg;

   // program counter and return store
   localparam int          PCU_PC_W          = 12;
   localparam int          PCU_STACK_DEPTH   = 6;
   localparam int          PCU_LOW_HALF_W    = 11;

   // vector locations in the fixed upper half of program space
   localparam logic [11:0] PCU_VEC_RESET     = 12'hffe;
   localparam logic [11:0] PCU_VEC_NMI       = 12'hffc;
   localparam logic [11:0] PCU_VEC_NONUSER_A = 12'hffa;
   localparam logic [11:0] PCU_VEC_NONUSER_B = 12'hff8;
   localparam logic [11:0] PCU_VEC_INT1      = 12'hff6;
   localparam logic [11:0] PCU_VEC_INT2      = 12'hff4;
   localparam logic [11:0] PCU_VEC_INT3      = 12'hff2;
   localparam logic [11:0] PCU_VEC_INT4      = 12'hff0;

   // data space locations
   localparam logic [7:0]  PCU_ADDR_PTR_ONE  = 8'h80;
   localparam logic [7:0]  PCU_ADDR_PTR_TWO  = 8'h81;
   localparam logic [7:0]  PCU_ADDR_SHORT3   = 8'h82;
   localparam logic [7:0]  PCU_ADDR_SHORT4   = 8'h83;
   localparam logic [7:0]  PCU_ADDR_ACC      = 8'hff;
   localparam logic [7:0]  PCU_ADDR_INT_OPT  = 8'hc8;
   localparam logic [7:0]  PCU_ADDR_ROM_WIN  = 8'hc9;
   localparam logic [7:0]  PCU_ADDR_RAM_BANK = 8'hca;
   localparam logic [7:0]  PCU_ADDR_PRG_BANK = 8'hcb;

   // paged areas of data space
   localparam logic [1:0]  PCU_RAM_PAGE_TOP  = 2'h0;
   localparam logic [1:0]  PCU_ROM_WIN_TOP   = 2'h1;
   localparam int          PCU_WIN_OFS_W     = 6;

   // interrupt option register fields
   localparam int          PCU_OPT_GEN_BIT   = 0;

   // reset values
   localparam logic [7:0]  PCU_REG_RESET     = 8'h00;
   localparam logic [7:0]  PCU_OPT_RESET     = 8'h00;

   typedef enum logic [1:0] {
      PCU_CTX_NORMAL,
      PCU_CTX_MASK,
      PCU_CTX_NMI
   } pcu_ctx_type;

endpackage

// ===== design/pcu_stack_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pcu_stack_if;
   logic        push;
   logic        pop;
   logic [11:0] push_data;
   logic [11:0] pop_data;
   logic        pop_valid;

   modport ctrl  (output push, output pop, output push_data, input pop_data, input pop_valid);
   modport store (input push, input pop, input push_data, output pop_data, output pop_valid);
endinterface

`default_nettype wire

// ===== design/pcu_return_stack.sv
`timescale 1ns/1ps
`default_nettype none

module pcu_return_stack
   import pcu_pkg::*;
#(
   parameter int DEPTH = PCU_STACK_DEPTH,
   parameter int WIDTH = PCU_PC_W
) (
   input  wire logic   clk,
   input  wire logic   reset_n,
   pcu_stack_if.store  stk
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    top;
   logic [AW-1:0]    below;

   assign below = (top == '0) ? LAST : top - AW'(1);

   // a seventh push wraps round onto the oldest slot, silently
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         top <= '0;
      end else if (stk.push) begin
         top <= (top == LAST) ? '0 : top + AW'(1);
      end else if (stk.pop) begin
         top <= below;
      end
   end

   always_ff @(posedge clk) begin
      if (stk.push) begin
         mem[top] <= stk.push_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stk.pop_data  <= '0;
         stk.pop_valid <= 1'b0;
      end else begin
         stk.pop_valid <= stk.pop & ~stk.push;
         if (stk.pop && !stk.push) begin
            stk.pop_data <= mem[below];
         end
      end
   end
endmodule

`default_nettype wire

// ===== design/pcu_program_control.sv
// Overview of operation
// - Twelve-bit program counter addresses the whole 4K program space directly.
// - Calls and accepted interrupts push the counter; returns pop it back.
// - The return store holds six counter entries.
// - Only call, interrupt and return reach the store; software cannot.
// - Three zero/carry pairs: normal, maskable service, non-maskable service.
// - Acknowledge selects the service pair; return restores the previous pair.
// - After reset the non-maskable pair is active, maskables refused until return.
// - Reset vector at the top pair, non-maskable vector just below.
// - Maskable vectors one to four descend from FF6 to FF0.
// - The two pairs below the non-maskable vector are never given to maskables.
// - Vector zero is the non-maskable input; one to four are maskable.
// - A detected interrupt runs one special cycle loading its vector address.
// - Non-maskable preempts maskable service, not its own; maskable never preempts maskable service.
// - Pending maskables are taken by fixed priority, one highest, four lowest.
// - The interrupt option register holds a global interrupt enable in bit 0.
// - The eight-bit accumulator sits at data location FF.
// - Four short-direct registers at 80-83; the first two also serve as pointers.
// - A 64-byte data window onto program ROM, paged by a six-bit register.
// - Data locations 00-3F are paged by a data RAM banking register.
// - Lower 2K of program space is banked; the upper 2K stays fixed.
`timescale 1ns/1ps
`default_nettype none

module pcu_program_control
   import pcu_pkg::*;
#(
   parameter int PBANK_W   = 4,
   parameter int ROMPAGE_W = 6,
   parameter int RAMPAGE_W = 8
) (
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   input  wire logic                          instr_boundary,
   input  wire logic                          pc_increment,
   input  wire logic                          jump_load,
   input  wire logic                          call_load,
   input  wire logic                          return_sub,
   input  wire logic                          return_from_service,
   input  wire logic [PCU_PC_W-1:0]           target_addr,
   input  wire logic                          flag_write,
   input  wire logic                          zero_in,
   input  wire logic                          carry_in,
   input  wire logic [7:0]                    ds_addr,
   input  wire logic                          ds_write,
   input  wire logic                          ds_read,
   input  wire logic [7:0]                    ds_wdata,
   input  wire logic                          nmi_pin,
   input  wire logic [4:1]                    irq_pin,
   output logic      [7:0]                    ds_rdata,
   output logic                               ds_hit,
   output logic      [PCU_PC_W-1:0]           program_counter,
   output logic      [PBANK_W+PCU_LOW_HALF_W-1:0] fetch_addr,
   output logic      [ROMPAGE_W+PCU_WIN_OFS_W-1:0] rom_window_addr,
   output logic                               rom_window_sel,
   output logic      [RAMPAGE_W-1:0]          ram_page,
   output logic                               ram_page_sel,
   output logic                               zero_flag,
   output logic                               carry_flag,
   output pcu_ctx_type                        service_ctx,
   output logic                               vector_cycle,
   output logic      [2:0]                    vector_index,
   output logic                               return_busy,
   output logic      [7:0]                    accumulator,
   output logic      [7:0]                    ptr_one,
   output logic      [7:0]                    ptr_two
);

   pcu_stack_if stk ();

   // return store is private: no data-space path reaches it
   // store not mapped
   pcu_return_stack #(
      .DEPTH (PCU_STACK_DEPTH),
      .WIDTH (PCU_PC_W)
   ) u_stack (
      .clk     (clk),
      .reset_n (reset_n),
      .stk     (stk)
   );

   // data-space registers
   logic [7:0]           short_three;
   logic [7:0]           short_four;
   logic [7:0]           int_option;
   logic [ROMPAGE_W-1:0] rom_page;
   logic [PBANK_W-1:0]   prog_bank;

   // flag pairs and service context
   logic [2:0]           zero_set;
   logic [2:0]           carry_set;
   pcu_ctx_type          nmi_saved_ctx;
   logic [1:0]           ctx_idx;

   // request synchronisers and pending nmi
   logic                 nmi_s1;
   logic                 nmi_s2;
   logic                 nmi_s2_d;
   logic                 nmi_pending;
   logic [4:1]           irq_s1;
   logic [4:1]           irq_s2;

   // arbitration
   logic                 global_en;
   logic                 take_nmi;
   logic                 take_irq;
   logic [2:0]           irq_sel;
   logic [PCU_PC_W-1:0]  vector_addr;
   logic                 core_op_ok;

   assign ctx_idx   = 2'(service_ctx);
   assign global_en = int_option[PCU_OPT_GEN_BIT];

   // both request inputs come from outside, two flops before use
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         nmi_s1 <= 1'b0;
         nmi_s2 <= 1'b0;
         irq_s1 <= '0;
         irq_s2 <= '0;
      end else begin
         nmi_s1 <= nmi_pin;
         nmi_s2 <= nmi_s1;
         irq_s1 <= irq_pin;
         irq_s2 <= irq_s1;
      end
   end

   // nmi is an edge event, held until its vector cycle; a new edge wins
   // a refused edge stays pending in nmi context; further edges merge into the one pending
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         nmi_s2_d    <= 1'b0;
         nmi_pending <= 1'b0;
      end else begin
         nmi_s2_d <= nmi_s2;
         if (nmi_s2 && !nmi_s2_d) begin
            nmi_pending <= 1'b1;
         end else if (vector_cycle && take_nmi) begin
            nmi_pending <= 1'b0;
         end
      end
   end

   always_comb begin
      irq_sel = 3'd0;
      for (int i = 4; i >= 1; i--) begin
         if (irq_s2[i]) begin
            irq_sel = 3'(i);
         end
      end
   end

   // nmi preempts, maskable only from normal
   // maskables held off in nmi context
   // global disable gates the nmi too; it waits pending meanwhile
   assign take_nmi = global_en & nmi_pending & (service_ctx != PCU_CTX_NMI);
   assign take_irq = global_en & (irq_sel != 3'd0) & (service_ctx == PCU_CTX_NORMAL);

   assign vector_cycle = instr_boundary & ~return_busy & (take_nmi | take_irq);
   assign vector_index = take_nmi ? 3'd0 : irq_sel;
   assign core_op_ok   = ~vector_cycle & ~return_busy;

   // maskable vectors descend from int one
   // non-user pairs never selected here
   // nmi fallback keeps an unused select harmless
   always_comb begin
      vector_addr = PCU_VEC_NMI;
      if (!take_nmi) begin
         unique case (irq_sel)
            3'd1:    vector_addr = PCU_VEC_INT1;
            3'd2:    vector_addr = PCU_VEC_INT2;
            3'd3:    vector_addr = PCU_VEC_INT3;
            3'd4:    vector_addr = PCU_VEC_INT4;
            default: vector_addr = PCU_VEC_NMI;
         endcase
      end
   end

   // push on call or vector, pop on return
   assign stk.push      = vector_cycle | (core_op_ok & call_load);
   assign stk.pop       = core_op_ok & (return_sub | return_from_service);
   assign stk.push_data = program_counter;

   // popped address lands one cycle after the return request
   // core ops are dropped meanwhile so the pop owns the counter
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         return_busy <= 1'b0;
      end else begin
         return_busy <= stk.pop;
      end
   end

   // counter starts at the reset vector
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         program_counter <= PCU_VEC_RESET;
      end else if (vector_cycle) begin
         program_counter <= vector_addr;
      end else if (stk.pop_valid) begin
         program_counter <= stk.pop_data;
      end else if (core_op_ok && (jump_load || call_load)) begin
         program_counter <= target_addr;
      end else if (core_op_ok && pc_increment) begin
         program_counter <= program_counter + PCU_PC_W'(1);
      end
   end

   // lower half banked, upper half fixed
   // vectors stay reachable whatever the bank register holds
   always_comb begin
      if (program_counter[PCU_PC_W-1]) begin
         fetch_addr = {{PBANK_W{1'b1}}, program_counter[PCU_LOW_HALF_W-1:0]};
      end else begin
         fetch_addr = {prog_bank, program_counter[PCU_LOW_HALF_W-1:0]};
      end
   end

   // context switch on acknowledge and return
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         service_ctx   <= PCU_CTX_NMI;
         nmi_saved_ctx <= PCU_CTX_NORMAL;
      end else if (vector_cycle && take_nmi) begin
         service_ctx   <= PCU_CTX_NMI;
         nmi_saved_ctx <= service_ctx;
      end else if (vector_cycle) begin
         service_ctx   <= PCU_CTX_MASK;
      end else if (core_op_ok && return_from_service) begin
         if (service_ctx == PCU_CTX_NMI) begin
            service_ctx <= nmi_saved_ctx;
         end else begin
            service_ctx <= PCU_CTX_NORMAL;
         end
         nmi_saved_ctx <= PCU_CTX_NORMAL;
      end
   end

   // three flag pairs, written in the active one
   // a context switch only moves the index; no flag copy needed
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         zero_set  <= '0;
         carry_set <= '0;
      end else if (flag_write) begin
         zero_set[ctx_idx]  <= zero_in;
         carry_set[ctx_idx] <= carry_in;
      end
   end

   assign zero_flag  = zero_set[ctx_idx];
   assign carry_flag = carry_set[ctx_idx];

   // accumulator at top of data space
   // short-direct registers at 80 to 83
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         accumulator <= PCU_REG_RESET;
         ptr_one     <= PCU_REG_RESET;
         ptr_two     <= PCU_REG_RESET;
         short_three <= PCU_REG_RESET;
         short_four  <= PCU_REG_RESET;
      end else if (ds_write) begin
         unique case (ds_addr)
            PCU_ADDR_ACC:     accumulator <= ds_wdata;
            PCU_ADDR_PTR_ONE: ptr_one     <= ds_wdata;
            PCU_ADDR_PTR_TWO: ptr_two     <= ds_wdata;
            PCU_ADDR_SHORT3:  short_three <= ds_wdata;
            PCU_ADDR_SHORT4:  short_four  <= ds_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         int_option <= PCU_OPT_RESET;
         rom_page   <= ROMPAGE_W'(PCU_REG_RESET);
         ram_page   <= RAMPAGE_W'(PCU_REG_RESET);
         prog_bank  <= PBANK_W'(PCU_REG_RESET);
      end else if (ds_write) begin
         unique case (ds_addr)
            PCU_ADDR_INT_OPT:  int_option <= ds_wdata;
            PCU_ADDR_ROM_WIN:  rom_page   <= ds_wdata[ROMPAGE_W-1:0];
            PCU_ADDR_RAM_BANK: ram_page   <= ds_wdata[RAMPAGE_W-1:0];
            PCU_ADDR_PRG_BANK: prog_bank  <= ds_wdata[PBANK_W-1:0];
            default: ;
         endcase
      end
   end

   // 64-byte window maps into program rom
   // lowest 64 bytes go through the ram page
   assign rom_window_sel  = (ds_addr[7:6] == PCU_ROM_WIN_TOP);
   assign ram_page_sel    = (ds_addr[7:6] == PCU_RAM_PAGE_TOP);
   assign rom_window_addr = {rom_page, ds_addr[PCU_WIN_OFS_W-1:0]};

   // read answer one cycle later; unowned locations give zero and no hit
   // rdata holds until the next read; ds_hit marks the fresh cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ds_rdata <= '0;
         ds_hit   <= 1'b0;
      end else if (ds_read) begin
         ds_hit <= 1'b1;
         unique case (ds_addr)
            PCU_ADDR_ACC:      ds_rdata <= accumulator;
            PCU_ADDR_PTR_ONE:  ds_rdata <= ptr_one;
            PCU_ADDR_PTR_TWO:  ds_rdata <= ptr_two;
            PCU_ADDR_SHORT3:   ds_rdata <= short_three;
            PCU_ADDR_SHORT4:   ds_rdata <= short_four;
            PCU_ADDR_INT_OPT:  ds_rdata <= int_option;
            PCU_ADDR_ROM_WIN:  ds_rdata <= 8'(rom_page);
            PCU_ADDR_RAM_BANK: ds_rdata <= 8'(ram_page);
            PCU_ADDR_PRG_BANK: ds_rdata <= 8'(prog_bank);
            default: begin
               ds_rdata <= '0;
               ds_hit   <= 1'b0;
            end
         endcase
      end else begin
         ds_hit <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ===== tb/pcu_irq_src.sv
`timescale 1ns/1ps
`default_nettype none

module pcu_irq_src (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic [4:1] req_irq,
   input  wire logic       req_nmi,
   output logic      [4:1] irq_pin,
   output logic            nmi_pin
);
   always_ff @(posedge clk) begin
      if (!reset_n) irq_pin <= 4'h0;
      else irq_pin <= req_irq;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) nmi_pin <= 1'b0;
      else nmi_pin <= req_nmi;
   end
endmodule

`default_nettype wire

// ===== tb/pcu_program_control_chk.sv
`timescale 1ns/1ps
`default_nettype none

module pcu_program_control_chk
   import pcu_pkg::*;
#(
   parameter int PBANK_W = 4
) (
   input wire logic                              clk,
   input wire logic                              reset_n,
   input wire logic                              instr_boundary,
   input wire logic                              call_load,
   input wire logic [PCU_PC_W-1:0]               target_addr,
   input wire logic [7:0]                        ds_addr,
   input wire logic                              ds_read,
   input wire logic                              ds_hit,
   input wire logic [PCU_PC_W-1:0]               program_counter,
   input wire logic [PBANK_W+PCU_LOW_HALF_W-1:0] fetch_addr,
   input wire pcu_ctx_type                       service_ctx,
   input wire logic                              vector_cycle,
   input wire logic [2:0]                        vector_index,
   input wire logic                              return_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_vec_pc;
      vector_cycle |=> program_counter == (($past(vector_index) == 3'h0) ? PCU_VEC_NMI
         : 12'hff8 - {8'h00, $past(vector_index), 1'b0});
   endproperty
   a_vec_pc: assert property (p_vec_pc) else $error("vector address wrong"); // vectors
   property p_vec_ctx;
      vector_cycle |=> service_ctx == (($past(vector_index) == 3'h0) ? PCU_CTX_NMI : PCU_CTX_MASK);
   endproperty
   a_vec_ctx: assert property (p_vec_ctx) else $error("flag set not switched"); // pair
   property p_no_nest;
      vector_cycle && service_ctx != PCU_CTX_NORMAL |-> vector_index == 3'h0;
   endproperty
   a_no_nest: assert property (p_no_nest) else $error("maskable nested"); // nesting
   property p_boundary;
      vector_cycle |-> instr_boundary && !return_busy && vector_index <= 3'h4;
   endproperty
   a_boundary: assert property (p_boundary) else $error("vector off boundary"); // sampling
   property p_call;
      call_load && !vector_cycle && !return_busy |=> program_counter == $past(target_addr);
   endproperty
   a_call: assert property (p_call) else $error("call target not loaded"); // call
   property p_busy;
      $rose(return_busy) |=> !return_busy;
   endproperty
   a_busy: assert property (p_busy) else $error("return busy too long"); // return
   property p_hit;
      ds_read && ds_addr inside {8'h80, 8'h81, 8'h82, 8'h83, 8'hff} |=> ds_hit;
   endproperty
   a_hit: assert property (p_hit) else $error("core register not answered"); // map
   property p_fetch;
      program_counter[11] |-> fetch_addr == {{PBANK_W{1'b1}}, program_counter[10:0]};
   endproperty
   a_fetch: assert property (p_fetch) else $error("upper half banked"); // fixed half
   property p_rst;
      $rose(reset_n) |-> service_ctx == PCU_CTX_NMI && program_counter == PCU_VEC_RESET;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong"); // reset set

   c_nmi: cover property (vector_cycle && vector_index == 3'h0);
   c_mask: cover property (vector_cycle && vector_index == 3'h4);
   c_ret: cover property ($rose(return_busy));
endmodule

bind pcu_program_control pcu_program_control_chk #(.PBANK_W(PBANK_W)) chk_u (
   .clk, .reset_n, .instr_boundary, .call_load, .target_addr, .ds_addr, .ds_read, .ds_hit,
   .program_counter, .fetch_addr, .service_ctx, .vector_cycle, .vector_index, .return_busy
);

`default_nettype wire

// ===== tb/test_pcu_program_control.sv
`timescale 1ns/1ps
`default_nettype none

module test_pcu_program_control;
   import pcu_pkg::*;
   logic clk, reset_n, instr_boundary, pc_increment, jump_load, call_load, return_sub;
   logic return_from_service, flag_write, zero_in, carry_in, ds_write, ds_read, nmi_pin;
   logic src_nmi, rom_window_sel, ram_page_sel, zero_flag, carry_flag, vector_cycle;
   logic return_busy, ds_hit;
   logic [11:0] target_addr, program_counter, rom_window_addr;
   logic [7:0]  ds_addr, ds_wdata, ds_rdata, ram_page, accumulator, ptr_one, ptr_two;
   logic [4:1]  irq_pin, src_irq;
   logic [14:0] fetch_addr;
   logic [2:0]  vector_index;
   pcu_ctx_type service_ctx;
   int          bad_count, comparisons, k;

   pcu_program_control dut_u (.clk, .reset_n, .instr_boundary, .pc_increment, .jump_load,
      .call_load, .return_sub, .return_from_service, .target_addr, .flag_write, .zero_in,
      .carry_in, .ds_addr, .ds_write, .ds_read, .ds_wdata, .nmi_pin, .irq_pin, .ds_rdata,
      .ds_hit, .program_counter, .fetch_addr, .rom_window_addr, .rom_window_sel, .ram_page,
      .ram_page_sel, .zero_flag, .carry_flag, .service_ctx, .vector_cycle, .vector_index,
      .return_busy, .accumulator, .ptr_one, .ptr_two);
   pcu_irq_src src_u (.clk, .reset_n, .req_irq(src_irq), .req_nmi(src_nmi), .irq_pin,
      .nmi_pin);

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // op bits: jump, call, return, return_from_service, increment
   task automatic op(input logic [4:0] m, input logic [11:0] t);
      @(posedge clk);
      {jump_load, call_load, return_sub, return_from_service, pc_increment} <= m;
      target_addr <= t;
      @(posedge clk);
      {jump_load, call_load, return_sub, return_from_service, pc_increment} <= 5'h00;
      @(posedge clk);
      @(negedge clk);
   endtask
   task automatic dsw(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      {ds_addr, ds_wdata, ds_write} <= {a, d, 1'b1};
      @(posedge clk);
      ds_write <= 1'b0;
   endtask
   task automatic dsr(input logic [7:0] a, input logic hit, input logic [7:0] d);
      @(posedge clk);
      {ds_addr, ds_read} <= {a, 1'b1};
      @(posedge clk);
      ds_read <= 1'b0;
      @(negedge clk);
      chk("ds_hit", ds_hit, hit); // answered
      chk("ds_rdata", ds_rdata, d); // read back
   endtask
   task automatic flg(input logic z, input logic c);
      @(posedge clk);
      {flag_write, zero_in, carry_in} <= {1'b1, z, c};
      @(posedge clk);
      flag_write <= 1'b0;
      @(negedge clk);
      chk("flags", {zero_flag, carry_flag}, {z, c}); // active pair
   endtask
   // irq sync plus nmi edge detect need at most four edges
   task automatic take(input logic [4:1] irq, input logic nmi, input logic [2:0] idx,
                       input logic vc);
      src_irq <= irq;
      src_nmi <= nmi;
      repeat (6) @(posedge clk);
      instr_boundary <= 1'b1;
      @(negedge clk);
      chk("vector_cycle", vector_cycle, vc); // acceptance
      if (vc) chk("vector_index", vector_index, idx); // priority
      @(posedge clk);
      instr_boundary <= 1'b0;
      @(negedge clk);
      if (vc) begin
         chk("vector pc", program_counter, idx == 0 ? 12'hffc : 12'hff8 - 2 * idx);
         chk("ctx", service_ctx, idx == 0 ? PCU_CTX_NMI : PCU_CTX_MASK); // switch
      end
   endtask

   task automatic t_regs;
      for (k = 0; k < 4; k++) dsw(8'h80 + 8'(k), 8'h31 + 8'(k));
      dsw(8'hff, 8'ha5);
      for (k = 0; k < 4; k++) dsr(8'h80 + 8'(k), 1'b1, 8'h31 + 8'(k));
      dsr(8'hff, 1'b1, 8'ha5);
      dsr(8'ha0, 1'b0, 8'h00);
      chk("regs", {accumulator, ptr_one, ptr_two}, {8'ha5, 8'h31, 8'h32}); // ports
      $display("test regs done");
   endtask
   task automatic t_refuse;
      chk("reset pc", program_counter, 12'hffe); // reset vector
      take(4'h1, 1'b0, 3'h0, 1'b0); // disabled
      dsw(8'hc8, 8'h01);
      take(4'h1, 1'b0, 3'h0, 1'b0); // still refused
      src_irq <= 4'h0;
      repeat (4) @(posedge clk);
      op(5'h02, 12'h000);
      chk("ctx", service_ctx, PCU_CTX_NORMAL); // released
      $display("test refuse done");
   endtask
   task automatic t_stack;
      op(5'h10, 12'h100);
      for (k = 1; k < 8; k++) op(5'h08, 12'h200 + 12'(k * 16));
      for (k = 6; k > 0; k--) begin
         op(5'h04, 12'h000);
         chk("pop pc", program_counter, 12'h200 + 12'(k * 16)); // oldest lost
      end
      $display("test stack done");
   endtask
   task automatic t_irq;
      flg(1'b1, 1'b0);
      src_irq <= 4'he;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk("no boundary", program_counter, 12'h210); // waits
      take(4'he, 1'b0, 3'h2, 1'b1); // two beats three
      flg(1'b0, 1'b1);
      take(4'he, 1'b0, 3'h0, 1'b0); // no nesting
      take(4'he, 1'b1, 3'h0, 1'b1); // preempt
      src_nmi <= 1'b0;
      op(5'h02, 12'h000);
      chk("nmi return", {service_ctx, program_counter}, {PCU_CTX_MASK, 12'hff4});
      chk("carry", carry_flag, 1'b1); // restored pair
      src_irq <= 4'h0;
      repeat (4) @(posedge clk);
      op(5'h02, 12'h000);
      chk("flags", {zero_flag, carry_flag}, 2'h2); // normal pair
      for (k = 1; k < 5; k++) begin
         take(4'(1 << (k - 1)), 1'b0, 3'(k), 1'b1); // each line
         src_irq <= 4'h0;
         repeat (4) @(posedge clk);
         op(5'h02, 12'h000);
         chk("ret pc", {service_ctx, program_counter}, {PCU_CTX_NORMAL, 12'h210});
      end
      $display("test irq done");
   endtask
   task automatic t_bank;
      dsw(8'hcb, 8'h05);
      op(5'h10, 12'h123);
      chk("fetch low", fetch_addr, {4'h5, 11'h123}); // banked
      op(5'h01, 12'h000);
      chk("increment", program_counter, 12'h124); // counter
      op(5'h10, 12'h923);
      chk("fetch high", fetch_addr, {4'hf, 11'h123}); // fixed
      dsw(8'hc9, 8'h2a);
      dsw(8'hca, 8'h03);
      @(posedge clk);
      ds_addr <= 8'h45;
      @(negedge clk);
      chk("rom win", {rom_window_sel, ram_page_sel, rom_window_addr}, 14'h2a85);
      chk("ram page", ram_page, 8'h03); // page
      @(posedge clk);
      ds_addr <= 8'h10;
      @(negedge clk);
      chk("ram sel", {rom_window_sel, ram_page_sel}, 2'h1); // low area
      $display("test bank done");
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      #(100 * 6000);
      bad_count++;
      print_verdict();
   end
   initial begin
      {reset_n, instr_boundary, pc_increment, jump_load, call_load, return_sub} = 6'h00;
      {return_from_service, flag_write, zero_in, carry_in, ds_write, ds_read} = 6'h00;
      {target_addr, ds_addr, ds_wdata, src_irq, src_nmi} = 33'h0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      t_refuse();
      t_regs();
      t_stack();
      t_irq();
      t_bank();
      print_verdict();
   end
endmodule

`default_nettype wire
